/* logic/nfc_config.sv */
// Flash interface configuration register with the byte sequencer that it steers.
//
// How it works
// - Config bit 31 low: read-data port reads launch no flash cycle; high: they do.
// - With triggering off, a port read still answers, with the last byte an earlier cycle caught.
// - Config bit 30 gates the sequencer and all flash control pin drivers.
// - Bits 27-24 give the number of address bytes sent per address transaction.
// - Bits 23-16 give the spare area byte count used to size block transfers.
// - Bits 15-0 give the page data byte count used to size block transfers.
// - Config register at 0x10 is read/write and resets to zero, all disabled.
// - Above four address bytes, the extended address write starts the cycles.
// - Block transfers move page plus spare bytes, plus one check byte when bit 28 is set.
`timescale 1ns/1ps
`include "nfc_cfg.svh"

module nfc_config
  import nfc_pkg::*;
(
  input wire logic mclk, // System clock, 250 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [7:0] addr, // Register byte address.
  input wire logic [31:0] wdata, // Write data.
  input wire logic wr, // Write strobe, one cycle.
  input wire logic rd, // Read strobe, one cycle.
  output logic [31:0] rdata, // Read data, valid the cycle after rd.
  input wire logic [7:0] fl_dq_i, // Flash data bus in.
  output logic [7:0] fl_dq_o, // Flash data bus out.
  output logic fl_dq_oe_n, // Flash data bus drive enable, low drives.
  output logic fl_ce_n, // Flash chip enable, active low.
  output logic fl_cle, // Command latch enable.
  output logic fl_ale, // Address latch enable.
  output logic fl_we_n, // Write strobe, active low.
  output logic fl_re_n // Read strobe, active low.
);

  nfc_regs_t r_ff;
  nfc_regs_t nxt_r;
  logic [7:0] ecc_par;
  logic ecc_clr;
  logic ecc_en;
  logic [7:0] ecc_din;

  // Bytes in one block transfer: page, then spare, then check code when enabled.
  function automatic logic [17:0] blk_total(input logic [31:0] c);
    logic [17:0] t;
    t = {2'b00, c[`NFC_CFG_PAGE_HI:`NFC_CFG_PAGE_LO]}
      + {10'h000, c[`NFC_CFG_SPARE_HI:`NFC_CFG_SPARE_LO]};
    if (c[`NFC_CFG_ECC_ENA_BIT]) begin
      t = t + `NFC_ECC_BYTES;
    end
    return t;
  endfunction : blk_total

  // Bytes of a block that carry data and feed the check code.
  function automatic logic [17:0] blk_data(input logic [31:0] c);
    return {2'b00, c[`NFC_CFG_PAGE_HI:`NFC_CFG_PAGE_LO]}
      + {10'h000, c[`NFC_CFG_SPARE_HI:`NFC_CFG_SPARE_LO]};
  endfunction : blk_data

  // Address byte n: four from the primary register, four from the extended, then zero.
  function automatic logic [7:0] addr_byte(input logic [31:0] lo, input logic [31:0] hi,
                                           input logic [17:0] n);
    logic [7:0] b;
    b = 8'h00;
    if (n < 18'h0_0004) begin
      b = lo[8 * n[1:0] +: 8];
    end else if (n < 18'h0_0008) begin
      b = hi[8 * n[1:0] +: 8];
    end
    return b;
  endfunction : addr_byte

  nfc_ecc u_ecc (
    .mclk(mclk),
    .rst(rst),
    .clr(ecc_clr),
    .en(ecc_en),
    .din(ecc_din),
    .par(ecc_par)
  );

  // Register writes, sequencer steps and pin levels, all into one next state.
  always_comb begin
    logic if_on;
    logic [3:0] asz;
    logic [17:0] total;
    logic [17:0] dlen;
    logic idle;
    logic done_set;
    logic err_set;
    if_on = r_ff.cfg[`NFC_CFG_IF_ENA_BIT];
    asz = r_ff.cfg[`NFC_CFG_ADDR_SIZE_HI:`NFC_CFG_ADDR_SIZE_LO];
    total = blk_total(r_ff.cfg);
    dlen = blk_data(r_ff.cfg);
    idle = (r_ff.state == NFC_IDLE);
    done_set = 1'b0;
    err_set = 1'b0;
    ecc_clr = 1'b0;
    ecc_en = 1'b0;
    ecc_din = 8'h00;
    nxt_r = r_ff;

    // Register writes; launches are taken only while the sequencer is idle.
    if (wr) begin
      if (addr == `NFC_OFS_CONFIG) begin
        nxt_r.cfg = wdata & `NFC_CFG_WR_MASK;
      end else if (addr == `NFC_OFS_ACTION) begin
        if (wdata[`NFC_ACT_CE_ENA_BIT]) begin
          nxt_r.ce_on = 1'b1;
        end else if (wdata[`NFC_ACT_CE_DIS_BIT]) begin
          nxt_r.ce_on = 1'b0;
        end
        if (if_on && idle && total != 18'h0_0000) begin
          if (wdata[`NFC_ACT_RD_KICK_BIT]) begin
            nxt_r.state = NFC_BRD;
            nxt_r.phase = 1'b0;
            nxt_r.cnt = 18'h0_0000;
            ecc_clr = 1'b1;
          end else if (wdata[`NFC_ACT_WR_KICK_BIT]) begin
            nxt_r.state = NFC_BWAIT;
            nxt_r.cnt = 18'h0_0000;
            ecc_clr = 1'b1;
          end
        end
      end else if (addr == `NFC_OFS_CMD) begin
        nxt_r.cmd = wdata[7:0];
        if (if_on && idle) begin
          nxt_r.state = NFC_CMD;
          nxt_r.phase = 1'b0;
          nxt_r.dq_o = wdata[7:0];
        end
      end else if (addr == `NFC_OFS_ADDR) begin
        nxt_r.addr_lo = wdata;
        // Short addresses start here; long ones wait for the extended word.
        if (if_on && idle && asz != 4'h0 && asz <= `NFC_ADDR_LO_BYTES) begin
          nxt_r.state = NFC_ADDR;
          nxt_r.phase = 1'b0;
          nxt_r.cnt = 18'h0_0000;
          nxt_r.dq_o = wdata[7:0];
        end
      end else if (addr == `NFC_OFS_ADDR_EXT) begin
        nxt_r.addr_hi = wdata;
        if (if_on && idle && asz > `NFC_ADDR_LO_BYTES) begin
          nxt_r.state = NFC_ADDR;
          nxt_r.phase = 1'b0;
          nxt_r.cnt = 18'h0_0000;
          nxt_r.dq_o = r_ff.addr_lo[7:0];
        end
      end else if (addr == `NFC_OFS_WR_PORT) begin
        nxt_r.wbyte = wdata[7:0];
        nxt_r.wr_pend = 1'b1;
      end
    end

    // Sequencer: phase 0 holds the strobe low, phase 1 releases it and ends the byte.
    case (r_ff.state)
      NFC_CMD: begin
        nxt_r.phase = ~r_ff.phase;
        if (r_ff.phase) begin
          nxt_r.state = NFC_IDLE;
        end
      end
      NFC_ADDR: begin
        nxt_r.phase = ~r_ff.phase;
        if (r_ff.phase) begin
          nxt_r.cnt = r_ff.cnt + 18'h0_0001;
          nxt_r.dq_o = addr_byte(r_ff.addr_lo, r_ff.addr_hi, r_ff.cnt + 18'h0_0001);
          if (r_ff.cnt + 18'h0_0001 == {14'h0000, asz}) begin
            nxt_r.state = NFC_IDLE;
          end
        end
      end
      NFC_SRD: begin
        nxt_r.phase = ~r_ff.phase;
        if (r_ff.phase) begin
          nxt_r.rd_byte = fl_dq_i;
          nxt_r.state = NFC_IDLE;
        end
      end
      NFC_BRD: begin
        nxt_r.phase = ~r_ff.phase;
        if (r_ff.phase) begin
          nxt_r.rd_byte = fl_dq_i;
          nxt_r.cnt = r_ff.cnt + 18'h0_0001;
          if (r_ff.cnt < dlen) begin
            ecc_en = 1'b1;
            ecc_din = fl_dq_i;
          end else if (fl_dq_i != ecc_par) begin
            err_set = 1'b1;
          end
          if (r_ff.cnt + 18'h0_0001 == total) begin
            nxt_r.state = NFC_IDLE;
            done_set = 1'b1;
          end
        end
      end
      NFC_BWAIT: begin
        // Data bytes wait for software; the check byte goes at once.
        if (r_ff.cnt >= dlen) begin
          nxt_r.state = NFC_BWR;
          nxt_r.phase = 1'b0;
          nxt_r.dq_o = ecc_par;
        end else if (r_ff.wr_pend) begin
          nxt_r.state = NFC_BWR;
          nxt_r.phase = 1'b0;
          nxt_r.dq_o = r_ff.wbyte;
          nxt_r.wr_pend = wr && addr == `NFC_OFS_WR_PORT;
        end
      end
      NFC_BWR: begin
        nxt_r.phase = ~r_ff.phase;
        if (r_ff.phase) begin
          nxt_r.cnt = r_ff.cnt + 18'h0_0001;
          if (r_ff.cnt < dlen) begin
            ecc_en = 1'b1;
            ecc_din = r_ff.dq_o;
          end
          if (r_ff.cnt + 18'h0_0001 == total) begin
            nxt_r.state = NFC_IDLE;
            done_set = 1'b1;
          end else begin
            nxt_r.state = NFC_BWAIT;
          end
        end
      end
      default: begin
        nxt_r.phase = 1'b0;
      end
    endcase

    // Register reads; a read-data port read may also launch one flash read.
    if (rd) begin
      if (addr == `NFC_OFS_CONFIG) begin
        nxt_r.rdata = r_ff.cfg;
      end else if (addr == `NFC_OFS_CMD) begin
        nxt_r.rdata = {24'h00_0000, r_ff.cmd};
      end else if (addr == `NFC_OFS_ADDR) begin
        nxt_r.rdata = r_ff.addr_lo;
      end else if (addr == `NFC_OFS_ADDR_EXT) begin
        nxt_r.rdata = r_ff.addr_hi;
      end else if (addr == `NFC_OFS_RD_PORT) begin
        // The answer is the byte caught by an earlier cycle; a cycle launched here shows at the next read.
        nxt_r.rdata = {24'h00_0000, r_ff.rd_byte};
        if (r_ff.cfg[`NFC_CFG_RD_ENA_BIT] && if_on && idle) begin
          nxt_r.state = NFC_SRD;
          nxt_r.phase = 1'b0;
        end
      end else if (addr == `NFC_OFS_STATUS) begin
        nxt_r.rdata = {29'h0000_0000, r_ff.blk_done, r_ff.ecc_err, ~idle};
      end else begin
        nxt_r.rdata = 32'h0000_0000;
      end
    end else begin
      nxt_r.rdata = 32'h0000_0000;
    end

    // Sticky flags clear on a written one; a same-cycle event keeps the flag set.
    if (wr && addr == `NFC_OFS_STATUS) begin
      if (wdata[`NFC_STS_ECC_ERR_BIT]) begin
        nxt_r.ecc_err = 1'b0;
      end
      if (wdata[`NFC_STS_DONE_BIT]) begin
        nxt_r.blk_done = 1'b0;
      end
    end
    if (err_set) begin
      nxt_r.ecc_err = 1'b1;
    end
    if (done_set) begin
      nxt_r.blk_done = 1'b1;
    end

    // Turning the interface off stops any transfer where it stands.
    if (!nxt_r.cfg[`NFC_CFG_IF_ENA_BIT]) begin
      nxt_r.state = NFC_IDLE;
      nxt_r.phase = 1'b0;
    end

    // Pin levels follow the next state, so every pin leaves a flip-flop.
    nxt_r.cle = (nxt_r.state == NFC_CMD);
    nxt_r.ale = (nxt_r.state == NFC_ADDR);
    nxt_r.we_n = ~((nxt_r.state == NFC_CMD || nxt_r.state == NFC_ADDR
                    || nxt_r.state == NFC_BWR) && !nxt_r.phase);
    nxt_r.re_n = ~((nxt_r.state == NFC_SRD || nxt_r.state == NFC_BRD) && !nxt_r.phase);
    nxt_r.dq_oe_n = ~(nxt_r.state == NFC_CMD || nxt_r.state == NFC_ADDR
                      || nxt_r.state == NFC_BWR);
    // Disabled pads rest inactive with the data bus released.
    nxt_r.ce_n = ~(nxt_r.ce_on && nxt_r.cfg[`NFC_CFG_IF_ENA_BIT]);
  end

  // Reset zeroes the configuration, so interface, check code and read launching are off; strobes, chip enable and drive enable reset high.
  always_ff @(posedge mclk) begin
    if (rst) begin
      r_ff <= '0;
      r_ff.cfg <= `NFC_CFG_RESET;
      r_ff.state <= NFC_IDLE;
      r_ff.dq_oe_n <= 1'b1;
      r_ff.ce_n <= 1'b1;
      r_ff.we_n <= 1'b1;
      r_ff.re_n <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign rdata = r_ff.rdata;
  assign fl_dq_o = r_ff.dq_o;
  assign fl_dq_oe_n = r_ff.dq_oe_n;
  assign fl_ce_n = r_ff.ce_n;
  assign fl_cle = r_ff.cle;
  assign fl_ale = r_ff.ale;
  assign fl_we_n = r_ff.we_n;
  assign fl_re_n = r_ff.re_n;

endmodule : nfc_config

/* inc/nfc_cfg.svh */
// Offsets, field positions, reset values and sizes of the flash configuration block.
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH

// Register byte offsets.
`define NFC_OFS_ACTION 8'h14
`define NFC_OFS_CONFIG 8'h10
`define NFC_OFS_CMD 8'h18
`define NFC_OFS_ADDR 8'h1C
`define NFC_OFS_ADDR_EXT 8'h20
`define NFC_OFS_RD_PORT 8'h24
`define NFC_OFS_WR_PORT 8'h28
`define NFC_OFS_STATUS 8'h2C

// Configuration register fields.
`define NFC_CFG_RD_ENA_BIT 31
`define NFC_CFG_IF_ENA_BIT 30
`define NFC_CFG_UNUSED_BIT 29
`define NFC_CFG_ECC_ENA_BIT 28
`define NFC_CFG_ADDR_SIZE_HI 27
`define NFC_CFG_ADDR_SIZE_LO 24
`define NFC_CFG_SPARE_HI 23
`define NFC_CFG_SPARE_LO 16
`define NFC_CFG_PAGE_HI 15
`define NFC_CFG_PAGE_LO 0
`define NFC_CFG_RESET 32'h0000_0000
`define NFC_CFG_WR_MASK 32'hDFFF_FFFF

// Action register bits.
`define NFC_ACT_CE_ENA_BIT 0
`define NFC_ACT_CE_DIS_BIT 1
`define NFC_ACT_RD_KICK_BIT 2
`define NFC_ACT_WR_KICK_BIT 3

// Status register bits.
`define NFC_STS_BUSY_BIT 0
`define NFC_STS_ECC_ERR_BIT 1
`define NFC_STS_DONE_BIT 2

// Address bytes held in the primary address register, and simple check-code length.
`define NFC_ADDR_LO_BYTES 4'h4
`define NFC_ECC_BYTES 18'h0_0001

`endif

/* inc/nfc_pkg.sv */
// Types shared by the flash configuration block.
package nfc_pkg;

  typedef enum logic [2:0] {
    NFC_IDLE,
    NFC_CMD,
    NFC_ADDR,
    NFC_SRD,
    NFC_BRD,
    NFC_BWAIT,
    NFC_BWR
  } nfc_state_t;

  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] addr_lo;
    logic [31:0] addr_hi;
    logic [7:0] cmd;
    logic [7:0] wbyte;
    logic wr_pend;
    logic [7:0] rd_byte;
    logic ce_on;
    logic ecc_err;
    logic blk_done;
    nfc_state_t state;
    logic phase;
    logic [17:0] cnt;
    logic [31:0] rdata;
    logic [7:0] dq_o;
    logic dq_oe_n;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
  } nfc_regs_t;

  typedef struct packed {
    logic [7:0] par;
  } nfc_ecc_t;

endpackage : nfc_pkg

/* logic/nfc_ecc.sv */
// Simple check-code generator: running XOR of the data bytes of one block.
`timescale 1ns/1ps
`include "nfc_cfg.svh"

module nfc_ecc
  import nfc_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic clr, // Starts a new block.
  input wire logic en, // One data byte passes.
  input wire logic [7:0] din, // The byte that passes.
  output logic [7:0] par // Check code so far.
);

  nfc_ecc_t r_ff;
  nfc_ecc_t nxt_r;

  // Clear wins over a byte in the same cycle; a kick never overlaps a transfer.
  always_comb begin
    nxt_r = r_ff;
    if (clr) begin
      nxt_r.par = 8'h00;
    end else if (en) begin
      nxt_r.par = r_ff.par ^ din;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign par = r_ff.par;

endmodule : nfc_ecc

/* tb/nfc_config_monitor.sv */
// Checker for the flash configuration block, bound to its ports.
`timescale 1ns/1ps
module nfc_config_monitor (
  input wire logic mclk, // Clock.
  input wire logic rst, // Reset.
  input wire logic [7:0] addr, // Address.
  input wire logic [31:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  input wire logic [31:0] rdata, // Read data.
  input wire logic [7:0] fl_dq_i, // Flash data in.
  input wire logic [7:0] fl_dq_o, // Flash data out.
  input wire logic fl_dq_oe_n, // Drive enable.
  input wire logic fl_ce_n, // Chip enable.
  input wire logic fl_cle, // Command latch.
  input wire logic fl_ale, // Address latch.
  input wire logic fl_we_n, // Write strobe.
  input wire logic fl_re_n // Read strobe.
);
  logic [31:0] cfg_ff;
  logic quiet_ff;
  logic quiet;
  logic idle;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Quiet pins for two cycles stand in for an idle sequencer; a block write waiting
  // for data looks the same, so port reads are never issued in that state.
  assign quiet = fl_re_n && fl_we_n && fl_dq_oe_n && !fl_cle && !fl_ale;
  assign idle = quiet && quiet_ff;
  // Shadow of the configuration word; bit 29 never stores.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_ff <= 32'h0000_0000;
      quiet_ff <= 1'b1;
    end else begin
      if (wr && addr == 8'h10) cfg_ff <= wdata & 32'hDFFF_FFFF;
      quiet_ff <= quiet;
    end
  end
  chk_cfg_readback: assert property (rd && addr == 8'h10 |=> rdata == cfg_ff)
    else $error("config readback differs");
  chk_unused_zero: assert property (rd && addr == 8'h10 |=> !rdata[29])
    else $error("bit 29 reads one");
  // Pins are checked in the same cycle: the enabling write itself may wake them next cycle.
  chk_if_gate: assert property (!cfg_ff[30] |-> fl_ce_n && fl_we_n && fl_re_n
    && fl_dq_oe_n && !fl_cle && !fl_ale) else $error("pins active while disabled");
  chk_trig_off: assert property (rd && addr == 8'h24 && !cfg_ff[31] && idle
    |=> fl_re_n [*2]) else $error("port read launched a cycle");
  chk_trig_on: assert property (rd && addr == 8'h24 && cfg_ff[31] && cfg_ff[30] && idle
    |=> !fl_re_n ##1 fl_re_n) else $error("port read did not launch");
  chk_cmd_cycle: assert property (wr && addr == 8'h18 && cfg_ff[30] && idle
    |=> (fl_cle && !fl_we_n && !fl_dq_oe_n && fl_dq_o == $past(wdata[7:0]))
    ##1 (fl_cle && fl_we_n) ##1 !fl_cle) else $error("command byte malformed");
  chk_rdata_idle: assert property (!rd |=> rdata == 32'h0000_0000)
    else $error("read data without a read");
  chk_port_upper: assert property (rd && addr == 8'h24 |=> rdata[31:8] == 24'h00_0000)
    else $error("port read upper bits set");
endmodule : nfc_config_monitor

bind nfc_config nfc_config_monitor u_mon (.mclk(mclk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
  .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_cle(fl_cle), .fl_ale(fl_ale),
  .fl_we_n(fl_we_n), .fl_re_n(fl_re_n));

/* tb/nfc_flash_model.sv */
// Behavioural flash memory that answers and counts the block's strobes.
`timescale 1ns/1ps
module nfc_flash_model (
  input wire logic mclk, // Timing reference.
  input wire logic [7:0] fl_dq_o, // Data from the block.
  input wire logic fl_ce_n, // Chip enable.
  input wire logic fl_cle, // Command latch.
  input wire logic fl_ale, // Address latch.
  input wire logic fl_we_n, // Write strobe.
  input wire logic fl_re_n, // Read strobe.
  output logic [7:0] mem_dq // Data to the block.
);
  int rd_cnt = 0;
  int wr_cnt = 0;
  int adr_cnt = 0;
  logic [7:0] idx = 8'h00;
  logic hold = 1'b0;
  logic [7:0] last_wr = 8'h00;
  logic [7:0] dq_ff = 8'h00;
  // One process owns the returned byte, so the data wire has a single driver.
  assign mem_dq = dq_ff;
  // Byte k after select is k^0x5A, held one cycle past the strobe, then inverted every
  // cycle, so a late sample sees the true byte only on alternate cycles.
  always @(posedge mclk) begin
    if (fl_ce_n) idx <= 8'h00;
    if (!fl_ce_n && !fl_re_n) begin
      dq_ff <= idx ^ 8'h5A;
      idx <= idx + 8'h01;
      rd_cnt <= rd_cnt + 1;
      hold <= 1'b1;
    end else if (hold) hold <= 1'b0;
    else dq_ff <= ~dq_ff;
    if (!fl_ce_n && !fl_we_n && fl_ale) adr_cnt <= adr_cnt + 1;
    if (!fl_ce_n && !fl_we_n && !fl_ale && !fl_cle) begin
      wr_cnt <= wr_cnt + 1;
      last_wr <= fl_dq_o;
    end
  end
endmodule : nfc_flash_model

/* tb/tb_top.sv */
// Self-checking bench for the flash configuration block.
`timescale 1ns/1ps
`define TB_CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rv = 32'h0000_0000;
  logic [7:0] fl_dq_i;
  logic [7:0] fl_dq_o;
  logic [7:0] mem_dq;
  logic fl_dq_oe_n, fl_ce_n, fl_cle, fl_ale, fl_we_n, fl_re_n;
  int err_total = 0;
  int num_checks = 0;
  int n;
  logic [31:0] bcfg [2] = '{32'h5000_0003, 32'h5002_0002};
  int btot [2] = '{4, 5};
  logic berr [2] = '{1'b0, 1'b1};
  always #2 mclk = ~mclk;
  // The shared data wire carries the block's byte while it drives, else the memory's.
  assign fl_dq_i = fl_dq_oe_n ? mem_dq : fl_dq_o;
  nfc_config u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
    .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_cle(fl_cle), .fl_ale(fl_ale),
    .fl_we_n(fl_we_n), .fl_re_n(fl_re_n));
  nfc_flash_model u_mem (.mclk(mclk), .fl_dq_o(fl_dq_o), .fl_ce_n(fl_ce_n),
    .fl_cle(fl_cle), .fl_ale(fl_ale), .fl_we_n(fl_we_n), .fl_re_n(fl_re_n),
    .mem_dq(mem_dq));
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rreg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rreg
  task automatic wait_done();
    rv = 32'h0000_0000;
    for (int i = 0; i < 100 && rv[2] !== 1'b1; i++) rreg(8'h2C);
  endtask : wait_done
  task automatic conclude();
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  // A run far beyond the expected few hundred cycles means a hang.
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rreg(8'h10); `TB_CHK(rv, 32'h0000_0000)
    rreg(8'h30); `TB_CHK(rv, 32'h0000_0000)
    wreg(8'h10, 32'hFFFF_FFFF);
    rreg(8'h10); `TB_CHK(rv, 32'hDFFF_FFFF)
    wreg(8'h10, 32'h4000_0000);
    wreg(8'h14, 32'h0000_0001);
    n = u_mem.rd_cnt;
    // With triggering off the port still answers, with zero since no byte has been caught yet.
    rreg(8'h24); `TB_CHK(rv, 32'h0000_0000)
    repeat (4) @(posedge mclk);
    `TB_CHK(u_mem.rd_cnt - n, 0)
    wreg(8'h10, 32'hC000_0000);
    rreg(8'h24);
    repeat (4) @(posedge mclk);
    rreg(8'h24); `TB_CHK(rv, 32'h0000_005A)
    repeat (4) @(posedge mclk);
    `TB_CHK(u_mem.rd_cnt - n, 2)
    wreg(8'h18, 32'h0000_0070);
    repeat (4) @(posedge mclk);
    rreg(8'h18); `TB_CHK(rv, 32'h0000_0070)
    // Three address bytes go out at once; five wait for the extended word.
    n = u_mem.adr_cnt;
    wreg(8'h10, 32'h4300_0000);
    wreg(8'h1C, 32'h0403_0201);
    repeat (10) @(posedge mclk);
    `TB_CHK(u_mem.adr_cnt - n, 3)
    wreg(8'h10, 32'h4500_0000);
    wreg(8'h1C, 32'h0403_0201);
    repeat (10) @(posedge mclk);
    `TB_CHK(u_mem.adr_cnt - n, 3)
    wreg(8'h20, 32'h0000_0005);
    repeat (14) @(posedge mclk);
    `TB_CHK(u_mem.adr_cnt - n, 8)
    rreg(8'h1C); `TB_CHK(rv, 32'h0403_0201)
    rreg(8'h20); `TB_CHK(rv, 32'h0000_0005)
    // Block reads with a matching and a failing check byte.
    for (int i = 0; i < 2; i++) begin
      wreg(8'h14, 32'h0000_0002);
      wreg(8'h14, 32'h0000_0001);
      wreg(8'h10, bcfg[i]);
      n = u_mem.rd_cnt;
      wreg(8'h14, 32'h0000_0004);
      wait_done();
      `TB_CHK(u_mem.rd_cnt - n, btot[i])
      `TB_CHK(rv[1], berr[i])
      wreg(8'h2C, 32'h0000_0006);
    end
    wreg(8'h10, 32'h5001_0002);
    n = u_mem.wr_cnt;
    wreg(8'h14, 32'h0000_0008);
    wreg(8'h28, 32'h0000_0011);
    repeat (4) @(posedge mclk);
    wreg(8'h28, 32'h0000_0022);
    repeat (4) @(posedge mclk);
    wreg(8'h28, 32'h0000_0044);
    wait_done();
    `TB_CHK(u_mem.wr_cnt - n, 4)
    `TB_CHK(u_mem.last_wr, 8'h77)
    // Disabling mid-transfer must leave chip enable, read strobe and drive enable high.
    wreg(8'h10, 32'h4000_0100);
    wreg(8'h14, 32'h0000_0004);
    repeat (20) @(posedge mclk);
    wreg(8'h10, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    `TB_CHK({fl_ce_n, fl_re_n, fl_dq_oe_n}, 3'b111)
    rreg(8'h10); `TB_CHK(rv, 32'h0000_0000)
    conclude();
  end
endmodule : tb_top
